// [cim_defines.svh]
`ifndef CIM_DEFINES_SVH
`define CIM_DEFINES_SVH
// Summary of operation
// - Armed counter measures one gate period, rising-to-rising or falling-to-falling.
// - Source edges of chosen polarity between the two gate edges are counted and returned.
// - Position count changes only after an arm event.
// - X1: up on A rise when A leads, down on A fall when B leads.
// - X2: count on both A edges, direction from leading channel.
// - X4: count on every A and B edge, direction from leading channel.
// - In X1, X2 and X4 (not two-pulse), index high in the programmed A/B phase loads the reload value.
// - A count step due together with reload is applied before the reload.
// - Reload completes within one timebase period; counting continues from it.
// - Two-pulse: up on an A rise without a B rise, down on a B rise without an A rise.
// - Buffered position: count captured on each sample edge and passed on.
// - Sampling never alters the position count; samples are cumulative since arm.
// - Sample clock arrives on gate input, rising or falling edge as configured.
// - Hardware-timed single point position behaves as buffered sample-clocked position.
// - Edge separation: after arm, active aux edge starts counting source edges.
// - Further aux edges are ignored once separation counting runs.
// - Active gate edge stops separation counting; count goes to result store.
// - Aux and gate active edges each selectable rising or falling.
// - After one stored separation result, inputs ignored until software reads it.

// Register word offsets
`define CIM_OFS_CTRL     4'h0
`define CIM_OFS_CMD      4'h1
`define CIM_OFS_RELOAD   4'h2
`define CIM_OFS_POSITION 4'h3
`define CIM_OFS_RESULT   4'h4
`define CIM_OFS_STATUS   4'h5

// Control fields
`define CIM_CTRL_MODE_LSB 0
`define CIM_CTRL_MODE_MSB 2
`define CIM_CTRL_GATE_POL 3
`define CIM_CTRL_SRC_POL  4
`define CIM_CTRL_AUX_POL  5
`define CIM_CTRL_SAMPLE   6
`define CIM_CTRL_PH_B     7
`define CIM_CTRL_PH_A     8
`define CIM_CTRL_IDX_EN   9
`define CIM_CTRL_W        10
`define CIM_CTRL_RST      10'h000

// Command bits
`define CIM_CMD_ARM    0
`define CIM_CMD_DISARM 1

// Status fields
`define CIM_ST_BUSY   0
`define CIM_ST_RVALID 1
`define CIM_ST_STATE  2

// Synchroniser lanes
`define CIM_IN_A   0
`define CIM_IN_B   1
`define CIM_IN_Z   2
`define CIM_IN_G   3
`define CIM_IN_X   4
`define CIM_IN_S   5
`define CIM_IN_N   6
`endif

// [cim_pkg.sv]
package cim_pkg;
    typedef enum logic [2:0] {
        CIM_PERIOD  = 3'h0,
        CIM_QX1     = 3'h1,
        CIM_QX2     = 3'h2,
        CIM_QX4     = 3'h3,
        CIM_TWOPULS = 3'h4,
        CIM_EDGESEP = 3'h5
    } cim_mode_t;

    typedef enum logic [1:0] {
        CIM_IDLE = 2'h0,
        CIM_WAIT = 2'h1,
        CIM_RUN  = 2'h2,
        CIM_DONE = 2'h3
    } cim_state_t;
endpackage

// [cim_counter.sv]
`include "cim_defines.svh"

module cim_counter #(
    parameter int CW = 32
) (
    input  wire logic          CORE_CLK,
    input  wire logic          SYS_RST,
    input  wire logic          ENC_A,
    input  wire logic          ENC_B,
    input  wire logic          ENC_Z,
    input  wire logic          GATE_IN,
    input  wire logic          AUX_IN,
    input  wire logic          SRC_IN,
    input  wire logic [3:0]    REG_ADDR,
    input  wire logic [CW-1:0] REG_WDATA,
    input  wire logic          REG_WR,
    input  wire logic          REG_RD,
    output logic      [CW-1:0] REG_RDATA,
    output logic               SMP_VALID,
    output logic      [CW-1:0] SMP_DATA
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`CIM_CTRL_W-1:0] ctrl;
        logic [CW-1:0]          reload;
        cim_pkg::cim_state_t    state;
        logic [CW-1:0]          count;
        logic [CW-1:0]          result;
        logic                   rvalid;
        logic [`CIM_IN_N-1:0]   meta;
        logic [`CIM_IN_N-1:0]   sync;
        logic [`CIM_IN_N-1:0]   prev;
        logic                   smp_valid;
        logic [CW-1:0]          smp_data;
        logic [CW-1:0]          rdata;
    } cim_regs_t;

    cim_regs_t q;
    cim_regs_t d;

    // ------------------------------------------------------------
    // Decoded controls and edges
    // ------------------------------------------------------------
    cim_pkg::cim_mode_t mode;
    logic               a;
    logic               b;
    logic               a_rise;
    logic               a_fall;
    logic               b_rise;
    logic               b_fall;
    logic               g_act;
    logic               x_act;
    logic               s_act;
    logic               up;
    logic               down;
    logic               is_pos;
    logic               reload_hit;
    logic               arm;
    logic               disarm;
    logic               wr_ctrl;
    logic               rd_result;

    assign mode = cim_pkg::cim_mode_t'(q.ctrl[`CIM_CTRL_MODE_MSB:`CIM_CTRL_MODE_LSB]);

    // Edges come only from the second and third stages
    assign a      = q.sync[`CIM_IN_A];
    assign b      = q.sync[`CIM_IN_B];
    assign a_rise = a & ~q.prev[`CIM_IN_A];
    assign a_fall = ~a & q.prev[`CIM_IN_A];
    assign b_rise = b & ~q.prev[`CIM_IN_B];
    assign b_fall = ~b & q.prev[`CIM_IN_B];

    // Polarity bit low selects the rising edge
    assign g_act = q.ctrl[`CIM_CTRL_GATE_POL] ?
                   (~q.sync[`CIM_IN_G] & q.prev[`CIM_IN_G]) :
                   (q.sync[`CIM_IN_G] & ~q.prev[`CIM_IN_G]);
    assign x_act = q.ctrl[`CIM_CTRL_AUX_POL] ?
                   (~q.sync[`CIM_IN_X] & q.prev[`CIM_IN_X]) :
                   (q.sync[`CIM_IN_X] & ~q.prev[`CIM_IN_X]);
    assign s_act = q.ctrl[`CIM_CTRL_SRC_POL] ?
                   (~q.sync[`CIM_IN_S] & q.prev[`CIM_IN_S]) :
                   (q.sync[`CIM_IN_S] & ~q.prev[`CIM_IN_S]);

    assign is_pos = (mode == cim_pkg::CIM_QX1) |
                    (mode == cim_pkg::CIM_QX2) |
                    (mode == cim_pkg::CIM_QX4) |
                    (mode == cim_pkg::CIM_TWOPULS);

    // ------------------------------------------------------------
    // Encoder step decode
    // ------------------------------------------------------------
    always_comb begin
        up   = 1'b0;
        down = 1'b0;
        unique case (mode)
            cim_pkg::CIM_QX1: begin
                // With B low, A rising means A leads; A falling means B led
                up   = a_rise & ~b;
                down = a_fall & ~b;
            end
            cim_pkg::CIM_QX2: begin
                up   = (a_rise & ~b) | (a_fall & b);
                down = (a_rise & b) | (a_fall & ~b);
            end
            cim_pkg::CIM_QX4: begin
                up   = (a_rise & ~b) | (a_fall & b) |
                       (b_rise & a) | (b_fall & ~a);
                down = (a_rise & b) | (a_fall & ~b) |
                       (b_rise & ~a) | (b_fall & a);
            end
            cim_pkg::CIM_TWOPULS: begin
                // Simultaneous rises cancel out
                up   = a_rise & ~b_rise;
                down = b_rise & ~a_rise;
            end
            default: begin
                up   = 1'b0;
                down = 1'b0;
            end
        endcase
    end

    // Reload is a level test, so deferring it one cycle behind a step is
    // harmless: the phase and index are still true on the next edge.
    assign reload_hit = q.ctrl[`CIM_CTRL_IDX_EN] & q.sync[`CIM_IN_Z] &
                        (mode != cim_pkg::CIM_TWOPULS) &
                        (a == q.ctrl[`CIM_CTRL_PH_A]) &
                        (b == q.ctrl[`CIM_CTRL_PH_B]);

    // ------------------------------------------------------------
    // Register strobes
    // ------------------------------------------------------------
    assign arm       = REG_WR & (REG_ADDR == `CIM_OFS_CMD) & REG_WDATA[`CIM_CMD_ARM];
    assign disarm    = REG_WR & (REG_ADDR == `CIM_OFS_CMD) & REG_WDATA[`CIM_CMD_DISARM];
    assign wr_ctrl   = REG_WR & (REG_ADDR == `CIM_OFS_CTRL);
    assign rd_result = REG_RD & (REG_ADDR == `CIM_OFS_RESULT);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d           = q;
        d.smp_valid = 1'b0;

        // Two-flop synchroniser plus one history stage
        d.meta = {SRC_IN, AUX_IN, GATE_IN, ENC_Z, ENC_B, ENC_A};
        d.sync = q.meta;
        d.prev = q.sync;

        // Measurement engine
        unique case (q.state)
            cim_pkg::CIM_IDLE: begin
                // Nothing counts until armed
            end
            cim_pkg::CIM_WAIT: begin
                if (mode == cim_pkg::CIM_EDGESEP) begin
                    if (x_act) begin
                        d.count = '0;
                        d.state = cim_pkg::CIM_RUN;
                    end
                end else if (g_act) begin
                    d.count = '0;
                    d.state = cim_pkg::CIM_RUN;
                end
            end
            cim_pkg::CIM_RUN: begin
                if (is_pos) begin
                    if (up) begin
                        d.count = q.count + 1'b1;
                    end else if (down) begin
                        d.count = q.count - 1'b1;
                    end else if (reload_hit) begin
                        d.count = q.reload;
                    end
                    // Sample edge copies the count and leaves it running
                    if (q.ctrl[`CIM_CTRL_SAMPLE] & g_act) begin
                        d.smp_valid = 1'b1;
                        d.smp_data  = q.count;
                    end
                end else begin
                    // Aux edges are not looked at while running
                    if (g_act) begin
                        d.result = q.count + (s_act ? 1'b1 : 1'b0);
                        d.rvalid = 1'b1;
                        d.state  = cim_pkg::CIM_DONE;
                    end else if (s_act) begin
                        d.count = q.count + 1'b1;
                    end
                end
            end
            cim_pkg::CIM_DONE: begin
                // All input edges ignored until the result is read
                if (rd_result) begin
                    d.state = cim_pkg::CIM_IDLE;
                end
            end
        endcase

        if (rd_result & (q.state != cim_pkg::CIM_RUN | ~g_act | is_pos)) begin
            d.rvalid = 1'b0;
        end

        // Software control; arm leaves the count as it is, so a preset written before it stands
        if (wr_ctrl) begin
            d.ctrl = REG_WDATA[`CIM_CTRL_W-1:0];
        end
        if (REG_WR & (REG_ADDR == `CIM_OFS_RELOAD)) begin
            d.reload = REG_WDATA;
        end
        if (REG_WR & (REG_ADDR == `CIM_OFS_POSITION) & (q.state != cim_pkg::CIM_RUN)) begin
            d.count = REG_WDATA;
        end
        if (disarm) begin
            d.state = cim_pkg::CIM_IDLE;
        end else if (arm) begin
            d.rvalid = 1'b0;
            if (is_pos) begin
                d.state = cim_pkg::CIM_RUN;
            end else begin
                d.state = cim_pkg::CIM_WAIT;
            end
        end

        // Read port: data one cycle after the strobe, zero otherwise
        d.rdata = '0;
        if (REG_RD) begin
            unique case (REG_ADDR)
                `CIM_OFS_CTRL: begin
                    d.rdata = CW'(q.ctrl);
                end
                `CIM_OFS_RELOAD: begin
                    d.rdata = q.reload;
                end
                `CIM_OFS_POSITION: begin
                    d.rdata = q.count;
                end
                `CIM_OFS_RESULT: begin
                    d.rdata = q.result;
                end
                `CIM_OFS_STATUS: begin
                    d.rdata                            = '0;
                    d.rdata[`CIM_ST_BUSY]              = (q.state == cim_pkg::CIM_WAIT) |
                                                         (q.state == cim_pkg::CIM_RUN);
                    d.rdata[`CIM_ST_RVALID]            = q.rvalid;
                    d.rdata[`CIM_ST_STATE+1:`CIM_ST_STATE] = q.state;
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            q           <= '0;
            q.ctrl      <= `CIM_CTRL_RST;
            q.state     <= cim_pkg::CIM_IDLE;
        end else begin
            q <= d;
        end
    end

    assign REG_RDATA = q.rdata;
    assign SMP_VALID = q.smp_valid;
    assign SMP_DATA  = q.smp_data;

endmodule

// [cim_enc_model.sv]
`include "cim_defines.svh"
module cim_enc_model (
    input  wire logic       clk,
    output logic      [5:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Encoder, gate, aux and source levels
    // ------------------------------------------------------------
    // Each level is held 6 clocks so the synchroniser never misses a change
    localparam int HOLD = 6;
    initial pins = 6'h00;
    task automatic drive(input int sel, input logic lvl);
        @(posedge clk);
        pins[sel] <= lvl;
        repeat (HOLD - 1) @(posedge clk);
    endtask
    task automatic pulse(input int sel, input int n);
        repeat (n) begin
            drive(sel, 1'b1);
            drive(sel, 1'b0);
        end
    endtask
    // Forward lets A lead B, reverse lets B lead; every cycle ends with both low
    task automatic quad(input logic fwd, input int n);
        for (int k = 0; k < 4 * n; k++) begin
            drive((((k % 2) == 0) == fwd) ? `CIM_IN_A : `CIM_IN_B, (k % 4) < 2);
        end
    endtask
endmodule

// [cim_counter_sva.sv]
module cim_counter_sva #(
    parameter int CW = 32
) (
    input wire logic          CORE_CLK,
    input wire logic          SYS_RST,
    input wire logic          GATE_IN,
    input wire logic [3:0]    REG_ADDR,
    input wire logic          REG_RD,
    input wire logic [CW-1:0] REG_RDATA,
    input wire logic          SMP_VALID,
    input wire logic [CW-1:0] SMP_DATA
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    sequence status_slot;
        $past(REG_RD) && $past(REG_ADDR) == 4'h5;
    endsequence
    sequence result_then_status;
        status_slot ##0 ($past(REG_RD, 2) && $past(REG_ADDR, 2) == 4'h4);
    endsequence
    chk_rd_idle: assert property (!$past(REG_RD) |-> REG_RDATA == '0)
        else $error("read data outside its slot");
    chk_unmapped_zero: assert property ($past(REG_RD) && $past(REG_ADDR) > 4'h5 |-> REG_RDATA == '0)
        else $error("unmapped read not zero");
    chk_status_pad: assert property (status_slot |-> REG_RDATA[CW-1:4] == '0)
        else $error("status spare bits set");
    chk_busy_state: assert property (status_slot |-> REG_RDATA[0] == (REG_RDATA[3:2] inside {2'h1, 2'h2}))
        else $error("busy flag disagrees with state");
    chk_result_clear: assert property (result_then_status |-> !REG_RDATA[1])
        else $error("result flag survives its read");
    // ------------------------------------------------------------
    // Sample path
    // ------------------------------------------------------------
    // Window assumes gate levels held at least 6 clocks
    sequence gate_moved;
        $past(GATE_IN, 2) != $past(GATE_IN, 6);
    endsequence
    chk_smp_pulse: assert property (SMP_VALID |=> !SMP_VALID)
        else $error("sample strobe longer than one cycle");
    chk_smp_hold: assert property (!SMP_VALID |-> $stable(SMP_DATA))
        else $error("sample data moved without strobe");
    chk_smp_gate: assert property (SMP_VALID |-> gate_moved)
        else $error("sample without gate edge");
endmodule

bind cim_counter cim_counter_sva #(.CW(CW)) cim_counter_sva_i (
    .CORE_CLK, .SYS_RST, .GATE_IN, .REG_ADDR, .REG_RD, .REG_RDATA, .SMP_VALID, .SMP_DATA
);

// [counter_input_measurement_test.sv]
`include "cim_defines.svh"
module counter_input_measurement_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic [31:0] rdata;
    logic        smp_v;
    logic [31:0] smp_d;
    logic [5:0]  pins;
    logic [31:0] smp_q[$];
    logic [31:0] v;
    logic [31:0] base;
    logic [31:0] r;
    int          f;
    int          b;
    int          mismatches = 0;
    int          n_checks = 0;
    always #2.5 clk = ~clk;
    cim_counter cim_counter_i (
        .CORE_CLK(clk), .SYS_RST(rst), .ENC_A(pins[`CIM_IN_A]), .ENC_B(pins[`CIM_IN_B]), .ENC_Z(pins[`CIM_IN_Z]),
        .GATE_IN(pins[`CIM_IN_G]), .AUX_IN(pins[`CIM_IN_X]), .SRC_IN(pins[`CIM_IN_S]), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .SMP_VALID(smp_v), .SMP_DATA(smp_d)
    );
    cim_enc_model enc_i (.clk(clk), .pins(pins));
    // Strobe is taken mid-cycle, where it stands settled for exactly one cycle
    always @(negedge clk) if (smp_v === 1'b1) smp_q.push_back(smp_d);
    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] quad_delta(int m, int up, int dn);
        return 32'((up - dn) * ((m == 3) ? 4 : m));
    endfunction
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #200us;
        mismatches++;
        summarize();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(63));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(4'h0, v);
        chk(v, 32'h0);
        rd(4'hc, v);
        chk(v, 32'h0);
        base = $urandom_range(1000, 100);
        wr(4'h0, 32'h3);
        wr(4'h3, base);
        enc_i.quad(1'b1, 1);
        rd(4'h3, v);
        chk(v, base);
        for (int m = 1; m <= 3; m++) begin
            f = $urandom_range(3, 1);
            b = $urandom_range(2, 0);
            wr(4'h0, 32'(m));
            wr(4'h3, base);
            wr(4'h1, 32'h1);
            enc_i.quad(1'b1, f);
            enc_i.quad(1'b0, b);
            rd(4'h3, v);
            chk(v, base + quad_delta(m, f, b));
            wr(4'h1, 32'h2);
        end
        wr(4'h0, 32'h4);
        wr(4'h3, base);
        wr(4'h1, 32'h1);
        // Preset while running must be ignored
        wr(4'h3, ~base);
        enc_i.pulse(`CIM_IN_A, f);
        enc_i.pulse(`CIM_IN_B, b);
        rd(4'h3, v);
        chk(v, base + 32'(f - b));
        wr(4'h1, 32'h2);
        for (int k = 0; k < 4; k++) begin
            r = $urandom();
            wr(4'h2, r);
            rd(4'h2, v);
            chk(v, r);
            wr(4'h0, 32'h203 | 32'(k == 1 || k == 2) << 8 | 32'(k > 1) << 7);
            wr(4'h3, base);
            wr(4'h1, 32'h1);
            enc_i.drive(`CIM_IN_Z, 1'b1);
            enc_i.quad(1'b1, 1);
            enc_i.drive(`CIM_IN_Z, 1'b0);
            rd(4'h3, v);
            chk(v, r + 32'((4 - k) % 4));
            wr(4'h1, 32'h2);
        end
        for (int g = 0; g < 2; g++) begin
            enc_i.drive(`CIM_IN_G, g[0]);
            wr(4'h0, 32'h43 | 32'(g) << 3);
            wr(4'h3, base);
            wr(4'h1, 32'h1);
            smp_q.delete();
            for (int i = 0; i < 3; i++) begin
                enc_i.quad(1'b1, 1);
                enc_i.drive(`CIM_IN_G, !g[0]);
                enc_i.drive(`CIM_IN_G, g[0]);
            end
            chk(32'(smp_q.size()), 32'h3);
            foreach (smp_q[i]) chk(smp_q[i], base + 32'(4 * (i + 1)));
            rd(4'h3, v);
            chk(v, base + 32'hc);
            wr(4'h1, 32'h2);
        end
        for (int p = 0; p < 4; p++) begin
            f = $urandom_range(5, 1);
            enc_i.drive(`CIM_IN_G, p[0]);
            wr(4'h0, 32'(p) << 3);
            wr(4'h1, 32'h1);
            rd(4'h5, v);
            chk(v, 32'h5);
            enc_i.drive(`CIM_IN_G, !p[0]);
            enc_i.pulse(`CIM_IN_S, f);
            enc_i.drive(`CIM_IN_G, p[0]);
            enc_i.drive(`CIM_IN_G, !p[0]);
            enc_i.pulse(`CIM_IN_S, 2);
            // A further gate period after the stored result must change nothing
            enc_i.drive(`CIM_IN_G, p[0]);
            enc_i.drive(`CIM_IN_G, !p[0]);
            rd(4'h5, v);
            chk(v, 32'he);
            rd(4'h4, v);
            chk(v, 32'(f));
        end
        for (int p = 0; p < 4; p++) begin
            f = $urandom_range(5, 1);
            enc_i.drive(`CIM_IN_G, p[0]);
            enc_i.drive(`CIM_IN_X, p[1]);
            wr(4'h0, 32'h5 | 32'(p[0]) << 3 | 32'(p[1]) << 5);
            wr(4'h1, 32'h1);
            enc_i.pulse(`CIM_IN_S, 1);
            enc_i.drive(`CIM_IN_G, !p[0]);
            enc_i.drive(`CIM_IN_G, p[0]);
            enc_i.drive(`CIM_IN_X, !p[1]);
            enc_i.pulse(`CIM_IN_S, f);
            enc_i.drive(`CIM_IN_X, p[1]);
            enc_i.drive(`CIM_IN_X, !p[1]);
            enc_i.pulse(`CIM_IN_S, 1);
            enc_i.drive(`CIM_IN_G, !p[0]);
            enc_i.pulse(`CIM_IN_S, 2);
            @(posedge clk);
            addr <= 4'h4;
            rd_s <= 1'b1;
            @(posedge clk);
            addr <= 4'h5;
            @(negedge clk);
            chk(rdata, 32'(f + 1));
            @(posedge clk);
            rd_s <= 1'b0;
            @(negedge clk);
            chk(rdata, 32'h0);
        end
        // Reset with the engine idle after the last read clears control and count
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(4'h3, v);
        chk(v, 32'h0);
        rd(4'h0, v);
        chk(v, 32'h0);
        summarize();
    end
endmodule
